//--- logic/wdg_defines.vh
// Constants for the watchdog and option latch block
`ifndef WDG_DEFINES_VH
`define WDG_DEFINES_VH
// ----------------------------------------
// Register indices; byte address is index * 4
// ----------------------------------------
`define WDG_OPT_IDX 16'h001F
`define WDG_SVC_IDX 16'hFFFF
`define WDG_STS_IDX 16'h0020
// ----------------------------------------
// Option latch fields and reset value
// ----------------------------------------
`define WDG_OPT_SLOWX 7
`define WDG_OPT_LVSTOP 6
`define WDG_OPT_LVRST 5
`define WDG_OPT_LVPWR 4
`define WDG_OPT_RATE 3
`define WDG_OPT_SHORT_STOP_RECOVERY 2
`define WDG_OPT_STOPEN 1
`define WDG_OPT_WDIS 0
`define WDG_OPT_RST 8'h30
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define WDG_STS_CAUSE 0
`define WDG_STS_WRITTEN 1
`define WDG_STS_RUN 2
// ----------------------------------------
// Timing in reference clock cycles
// ----------------------------------------
`define WDG_TMO_LONG 18'h3FFF0
`define WDG_TMO_SHORT 18'h01FF0
`define WDG_STRETCH 13'h0020
`define WDG_REC_SHORT 13'h0020
`define WDG_REC_LONG 13'h1000
`define WDG_POR_DLY 13'h1000
`define WDG_DLY_W 13
`endif

//--- logic/wdg_sync.v
// Two-flop synchroniser for asynchronous pins
module wdg_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- logic/wdg_dcnt.v
// Loadable down-counter giving a busy level and a done pulse
module wdg_dcnt #(
	parameter W = 13
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Control
	input wire load,
	input wire [W-1:0] val,
	// Status
	output reg busy,
	output reg done
);
	reg [W-1:0] cnt_r;

	// Done rises val edges after the load edge
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= {W{1'b0}};
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_r <= val;
				busy <= 1'b1;
			end else if (cnt_r != {W{1'b0}}) begin
				cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
				if (cnt_r == {{(W-1){1'b0}}, 1'b1}) begin
					done <= 1'b1;
					busy <= 1'b0;
				end
			end
		end
	end
endmodule

//--- logic/wdg_top.v
// Watchdog with write-once option latch on an AHB-Lite slave
//
// Decided for this implementation: register access over AHB-Lite.
`include "wdg_defines.vh"
module wdg_top #(
	parameter [7:0] RST_VEC_LO = 8'h00,
	parameter PRE_W = 12,
	parameter CNT_W = 6
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	// Core events, same clock
	input wire sys_rst_in,
	input wire stop_req,
	input wire stop_mode,
	input wire wait_mode,
	input wire stop_wake,
	input wire wake_by_reset,
	input wire vec_fetch,
	// Pins from outside the clock domain
	input wire monitor_mode,
	input wire break_state,
	input wire irq_test_voltage,
	input wire rst_test_voltage,
	input wire lowvolt_reset_req,
	// Reset pin, open drain
	output reg rst_pin_o,
	output reg rst_pin_oe_n,
	// System reset and stop control
	output reg sys_reset,
	output reg stop_ack,
	output reg illegal_op,
	output reg stop_release,
	// Option outputs
	output reg lowvolt_power_en,
	output reg lowvolt_in_stop_act,
	output reg slow_crystal_sel
);
	localparam TW = PRE_W + CNT_W;
	localparam [17:0] OPT_A = {`WDG_OPT_IDX, 2'b00};
	localparam [17:0] SVC_A = {`WDG_SVC_IDX, 2'b00};
	localparam [17:0] STS_A = {`WDG_STS_IDX, 2'b00};

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Every pin is treated as asynchronous to the reference clock
	wire [4:0] pins_s;

	wdg_sync #(.W(5)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({monitor_mode, break_state, irq_test_voltage, rst_test_voltage, lowvolt_reset_req}),
		.q(pins_s)
	);

	wire mon_s = pins_s[4];
	wire brk_s = pins_s[3];
	wire irq_tv_s = pins_s[2];
	wire rst_tv_s = pins_s[1];
	wire lv_req_s = pins_s[0];

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	reg dp_wr_r;
	reg [17:0] dp_addr_r;
	wire ap_take = hsel & htrans[1] & hready;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r <= 1'b0;
			dp_addr_r <= 18'h00000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			// Zero wait state; response is always OKAY
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			dp_wr_r <= ap_take & hwrite;
			if (ap_take) begin
				dp_addr_r <= haddr[17:0];
			end
		end
	end

	wire wr_opt = dp_wr_r & (dp_addr_r == OPT_A);
	wire wr_svc = dp_wr_r & (dp_addr_r == SVC_A);
	wire wr_sts = dp_wr_r & (dp_addr_r == STS_A);

	// ----------------------------------------
	// Option latch
	// ----------------------------------------
	reg [7:0] opt_r;
	reg opt_done_r;

	// An internal reset reopens the latch as well as restoring the defaults
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opt_r <= `WDG_OPT_RST;
			opt_done_r <= 1'b0;
		end else if (sys_rst_in) begin
			opt_r <= `WDG_OPT_RST;
			opt_done_r <= 1'b0;
		end else if (wr_opt && !opt_done_r) begin
			opt_r <= hwdata[7:0];
			opt_done_r <= 1'b1;
		end
	end

	wire rate_sel = opt_r[`WDG_OPT_RATE];
	wire stop_en = opt_r[`WDG_OPT_STOPEN];
	wire wd_dis = opt_r[`WDG_OPT_WDIS];

	// ----------------------------------------
	// Watchdog enable and clears
	// ----------------------------------------
	// Wait mode deliberately has no term here: the count goes on
	wire mon_dis = (mon_s & (irq_tv_s | rst_tv_s)) | (brk_s & rst_tv_s);
	wire wd_on = ~wd_dis & ~mon_dis;
	wire wd_run = wd_on & ~stop_mode;
	wire stop_go = stop_req & stop_en;

	reg ovf_r;
	wire por_done;
	wire int_clr = sys_rst_in | ovf_r;
	wire pre_clr = stop_go | por_done | vec_fetch;

	// ----------------------------------------
	// Prescaler and counter
	// ----------------------------------------
	// One register holds both stages: the top CNT_W bits are the counter,
	// so the prescaler carry needs no logic of its own
	reg [TW-1:0] cnt_r;
	wire [TW-1:0] tmo = rate_sel ? `WDG_TMO_SHORT : `WDG_TMO_LONG;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= {TW{1'b0}};
		end else if (int_clr) begin
			cnt_r <= {TW{1'b0}};
		end else begin
			if (wr_svc) begin
				// Stages 1 to 4 keep their count across a service write; they hold for that cycle
				cnt_r <= {{(TW-4){1'b0}}, cnt_r[3:0]};
			end else if (pre_clr) begin
				cnt_r <= {cnt_r[TW-1:PRE_W], {PRE_W{1'b0}}};
			end else if (wd_run) begin
				cnt_r <= cnt_r + {{(TW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ----------------------------------------
	// Overflow and system reset
	// ----------------------------------------
	// Comparing for equality instead of waiting for a carry lets one
	// counter serve both timeouts; a service write in the same cycle wins
	wire ovf_hit = wd_run & ~wr_svc & (cnt_r == tmo);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_r <= 1'b0;
			sys_reset <= 1'b0;
		end else begin
			ovf_r <= ovf_hit & ~int_clr;
			// Only a reset leaves the block; no interrupt path exists
			sys_reset <= ovf_hit & ~int_clr | (lv_req_s & opt_r[`WDG_OPT_LVRST]);
		end
	end

	// ----------------------------------------
	// Reset pin stretch
	// ----------------------------------------
	// The pin is only ever pulled low; the enable alone carries the pulse
	wire str_busy;

	wdg_dcnt #(.W(`WDG_DLY_W)) u_stretch (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(ovf_r),
		.val(`WDG_STRETCH),
		.busy(str_busy),
		.done()
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_pin_o <= 1'b0;
			rst_pin_oe_n <= 1'b1;
		end else begin
			rst_pin_o <= 1'b0;
			rst_pin_oe_n <= ~str_busy;
		end
	end

	// ----------------------------------------
	// Power-up prescaler clear
	// ----------------------------------------
	// Loads the delay once, at the first edge after release, and never again
	reg por_go_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			por_go_r <= 1'b0;
		end else begin
			por_go_r <= 1'b1;
		end
	end

	wdg_dcnt #(.W(`WDG_DLY_W)) u_por (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(~por_go_r),
		.val(`WDG_POR_DLY),
		.busy(),
		.done(por_done)
	);

	// ----------------------------------------
	// Stop instruction and stop recovery
	// ----------------------------------------
	wire [`WDG_DLY_W-1:0] rec_val;
	wire rec_done;

	// Exit through reset ignores the short option
	assign rec_val = (opt_r[`WDG_OPT_SHORT_STOP_RECOVERY] & ~wake_by_reset) ? `WDG_REC_SHORT : `WDG_REC_LONG;

	wdg_dcnt #(.W(`WDG_DLY_W)) u_rec (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(stop_wake),
		.val(rec_val),
		.busy(),
		.done(rec_done)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_ack <= 1'b0;
			illegal_op <= 1'b0;
			stop_release <= 1'b0;
		end else begin
			stop_ack <= stop_go;
			illegal_op <= stop_req & ~stop_en;
			stop_release <= rec_done;
		end
	end

	// ----------------------------------------
	// Low-voltage detector and clock options
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lowvolt_power_en <= 1'b0;
			lowvolt_in_stop_act <= 1'b0;
			slow_crystal_sel <= 1'b0;
		end else begin
			lowvolt_power_en <= opt_r[`WDG_OPT_LVPWR];
			lowvolt_in_stop_act <= opt_r[`WDG_OPT_LVPWR] & opt_r[`WDG_OPT_LVSTOP];
			slow_crystal_sel <= opt_r[`WDG_OPT_SLOWX];
		end
	end

	// ----------------------------------------
	// Reset cause flag
	// ----------------------------------------
	// Survives internal resets so software can see why it restarted
	reg cause_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_r <= 1'b0;
		end else if (ovf_r) begin
			cause_r <= 1'b1;
		end else if (wr_sts && hwdata[`WDG_STS_CAUSE]) begin
			cause_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Reads have no side effects, so data is prepared in the address phase
	// Unmapped offsets read as zero
	reg [31:0] rd_nxt;

	always @* begin
		rd_nxt = 32'h00000000;
		if (haddr[17:0] == OPT_A) begin
			rd_nxt[7:0] = opt_r;
		end else if (haddr[17:0] == SVC_A) begin
			rd_nxt[7:0] = RST_VEC_LO;
		end else if (haddr[17:0] == STS_A) begin
			rd_nxt[`WDG_STS_CAUSE] = cause_r | ovf_r;
			rd_nxt[`WDG_STS_WRITTEN] = opt_done_r;
			rd_nxt[`WDG_STS_RUN] = wd_run;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ap_take && !hwrite) begin
			hrdata <= rd_nxt;
		end
	end
endmodule

//--- verification/wdg_top_properties.sv
// Port assertions for the watchdog block
module wdg_props #(
	parameter [7:0] RST_VEC_LO = 8'h00
) (
	// Clock and reset
	input logic hclk,
	input logic hresetn,
	// Bus
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hresp,
	input logic [31:0] hrdata,
	// Core events
	input logic sys_rst_in,
	input logic stop_req,
	input logic stop_wake,
	input logic wake_by_reset,
	input logic lowvolt_reset_req,
	// Watched outputs
	input logic rst_pin_o,
	input logic rst_pin_oe_n,
	input logic sys_reset,
	input logic stop_ack,
	input logic illegal_op,
	input logic stop_release
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	int tcnt_r, wcnt_r, lcnt_r;
	logic long_r;
	wire svc = hsel && htrans[1] && hready && haddr[17:0] == 18'h3FFFC;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tcnt_r <= 0;
			wcnt_r <= 0;
			lcnt_r <= 0;
			long_r <= 1'h0;
		end else begin
			// Slack in the window absorbs the uncleared low stages
			tcnt_r <= (svc && hwrite) || sys_rst_in || sys_reset ? 0 : tcnt_r + 1;
			wcnt_r <= stop_wake ? 0 : wcnt_r + 1;
			long_r <= stop_wake ? wake_by_reset : long_r;
			lcnt_r <= rst_pin_oe_n ? 0 : lcnt_r + 1;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence svc_rd;
		svc && !hwrite;
	endsequence
	sequence wd_ovf;
		$rose(sys_reset) && !lowvolt_reset_req;
	endsequence
	AST_TMO: assert property (wd_ovf |-> tcnt_r inside {[8155:8182], [262107:262134]})
		else $error("watchdog reset outside its timeout window");
	AST_OVF_PIN: assert property (wd_ovf |=> ##[0:2] !rst_pin_oe_n)
		else $error("reset pin not pulled after overflow");
	AST_STRETCH: assert property ($rose(rst_pin_oe_n) |-> lcnt_r == 32)
		else $error("reset pin low time wrong");
	AST_PIN_LOW: assert property (rst_pin_o == 1'h0)
		else $error("reset pin driven high");
	AST_READ: assert property (svc_rd |=> hrdata == {24'h0, RST_VEC_LO})
		else $error("service read data wrong");
	AST_STOP: assert property (stop_req |=> stop_ack != illegal_op)
		else $error("stop answer wrong");
	AST_REC: assert property (stop_release |-> (wcnt_r == 33 && !long_r) || wcnt_r == 4097)
		else $error("stop recovery delay wrong");
	AST_OKAY: assert property (hresp == 1'h0)
		else $error("bus response not okay");
endmodule
bind wdg_top wdg_props #(.RST_VEC_LO(RST_VEC_LO)) u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hresp(hresp), .hrdata(hrdata),
	.sys_rst_in(sys_rst_in), .stop_req(stop_req), .stop_wake(stop_wake), .wake_by_reset(wake_by_reset),
	.lowvolt_reset_req(lowvolt_reset_req), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
	.sys_reset(sys_reset), .stop_ack(stop_ack), .illegal_op(illegal_op), .stop_release(stop_release));

//--- verification/test_watchdog_with_option_latch.sv
// Self-checking bench for the watchdog with write-once option latch
`include "wdg_defines.vh"
module test_watchdog_with_option_latch;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} wdg_row_t;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic sys_rst_in = 1'h0, stop_req = 1'h0, stop_mode = 1'h0, wait_mode = 1'h0;
	logic stop_wake = 1'h0, wake_by_reset = 1'h0, lowvolt_reset_req = 1'h0, rst_seen = 1'h0;
	logic monitor_mode = 1'h0, irq_test_voltage = 1'h0;
	logic hreadyout, hresp, rst_pin_o, rst_pin_oe_n, sys_reset, stop_ack, illegal_op, stop_release;
	logic lowvolt_power_en, lowvolt_in_stop_act, slow_crystal_sel;
	wire logic hready = hreadyout;
	int failures = 0, cmp_count = 0, cyc = 0, n;
	// Second latch write must be ignored, so the readback stays 8'hFE
	wdg_row_t rows[11] = '{
		'{1'h0, 32'h7C, 32'h0, {24'h0, `WDG_OPT_RST}}, '{1'h0, 32'h3FFFC, 32'h0, 32'h0},
		'{1'h0, 32'h80, 32'h0, 32'h4}, '{1'h1, 32'h7C, 32'hFE, 32'h0}, '{1'h0, 32'h7C, 32'h0, 32'hFE},
		'{1'h1, 32'h7C, 32'h0, 32'h0}, '{1'h0, 32'h7C, 32'h0, 32'hFE}, '{1'h0, 32'h80, 32'h0, 32'h6},
		'{1'h0, 32'h100, 32'h0, 32'h0}, '{1'h1, 32'h3FFFC, 32'h55, 32'h0}, '{1'h0, 32'h3FFFC, 32'h0, 32'h0}};
	wdg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sys_rst_in(sys_rst_in), .stop_req(stop_req), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.stop_wake(stop_wake), .wake_by_reset(wake_by_reset), .vec_fetch(1'h0), .monitor_mode(monitor_mode),
		.break_state(1'h0), .irq_test_voltage(irq_test_voltage), .rst_test_voltage(1'h0),
		.lowvolt_reset_req(lowvolt_reset_req), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
		.sys_reset(sys_reset), .stop_ack(stop_ack), .illegal_op(illegal_op), .stop_release(stop_release),
		.lowvolt_power_en(lowvolt_power_en), .lowvolt_in_stop_act(lowvolt_in_stop_act),
		.slow_crystal_sel(slow_crystal_sel));
	// ----------------------------------------
	// Clock, watchdog of the run, helpers
	// ----------------------------------------
	always #50 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (sys_reset === 1'h1)
			rst_seen <= 1'h1;
		if (cyc == 40000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic wait_hi(input int sel, output int cnt);
		cnt = 0;
		do begin
			@(posedge hclk);
			cnt++;
		end while (!(sel == 0 ? sys_reset === 1'h1 : sel == 1 ? stop_release === 1'h1 : rst_pin_oe_n === 1'h0));
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		foreach (rows[i]) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk("row read", rows[i].e, rd);
		end
		chk("slow crystal", 32'h1, {31'h0, slow_crystal_sel});
		chk("lowvolt power", 32'h1, {31'h0, lowvolt_power_en});
		chk("lowvolt in stop", 32'h1, {31'h0, lowvolt_in_stop_act});
		$display("Test map done");
		wait_mode <= 1'h1;
		rst_seen <= 1'h0;
		repeat (3) begin
			repeat (4000) @(posedge hclk);
			bus(1'h1, 32'h3FFFC, 32'h0);
		end
		chk("no reset while serviced", 32'h0, {31'h0, rst_seen});
		$display("Test service done");
		stop_req <= 1'h1;
		@(posedge hclk);
		stop_req <= 1'h0;
		stop_mode <= 1'h1;
		@(posedge hclk);
		chk("stop ack", 32'h1, {31'h0, stop_ack});
		for (int k = 0; k < 2; k++) begin
			wake_by_reset <= k[0];
			stop_wake <= 1'h1;
			@(posedge hclk);
			stop_wake <= 1'h0;
			wait_hi(1, n);
			chk("recovery", k ? `WDG_REC_LONG + 2 : `WDG_REC_SHORT + 2, n);
		end
		stop_mode <= 1'h0;
		$display("Test stop done");
		bus(1'h1, 32'h3FFFC, 32'h0);
		wait_hi(0, n);
		chk("timeout window", 32'h1, {31'h0, n > 8150 && n < 8180});
		wait_hi(2, n);
		n = 0;
		while (rst_pin_oe_n === 1'h0) begin
			@(posedge hclk);
			n++;
		end
		chk("pin low cycles", `WDG_STRETCH, n);
		bus(1'h0, 32'h80, 32'h0);
		chk("cause flag", 32'h1, rd & 32'h1);
		bus(1'h1, 32'h80, 32'h1);
		bus(1'h0, 32'h80, 32'h0);
		chk("cause cleared", 32'h0, rd & 32'h1);
		$display("Test timeout done");
		sys_rst_in <= 1'h1;
		repeat (2) @(posedge hclk);
		sys_rst_in <= 1'h0;
		bus(1'h0, 32'h7C, 32'h0);
		chk("latch restored", {24'h0, `WDG_OPT_RST}, rd);
		lowvolt_reset_req <= 1'h1;
		repeat (5) @(posedge hclk);
		chk("lowvolt reset passed", 32'h1, {31'h0, sys_reset});
		lowvolt_reset_req <= 1'h0;
		bus(1'h1, 32'h7C, 32'h40);
		lowvolt_reset_req <= 1'h1;
		repeat (5) @(posedge hclk);
		chk("lowvolt reset blocked", 32'h0, {31'h0, sys_reset});
		chk("lowvolt power off", 32'h0, {31'h0, lowvolt_power_en});
		chk("lowvolt stop gated", 32'h0, {31'h0, lowvolt_in_stop_act});
		lowvolt_reset_req <= 1'h0;
		stop_req <= 1'h1;
		@(posedge hclk);
		stop_req <= 1'h0;
		@(posedge hclk);
		chk("illegal stop", 32'h1, {31'h0, illegal_op});
		$display("Test lowvolt done");
		monitor_mode <= 1'h1;
		irq_test_voltage <= 1'h1;
		repeat (4) @(posedge hclk);
		bus(1'h0, 32'h80, 32'h0);
		chk("monitor disable", 32'h0, rd & 32'h4);
		$display("Test monitor done");
		tally_and_finish();
	end
endmodule
